// >>> src/tlvi_top.sv
// Purpose: two-priority-level vectored interrupt unit
// Assumes: mc_end pulses once per machine cycle at state 5 phase 2
// Notes: registers over AXI4-Lite; sequencer does the stack push
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "tlvi_defs.svh"
module tlvi_top (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire tlvi_pkg::tlvi_axi_req_t axi_req,
	output tlvi_pkg::tlvi_axi_rsp_t axi_rsp,
	// Instruction sequencer
	input wire logic mc_end,
	input wire logic last_cycle,
	input wire logic return_from_isr_exec,
	output logic call_valid,
	output logic [15:0] call_vector,
	output logic [1:0] inprog,
	// Event sources
	input wire logic ext_irq0_pin,
	input wire logic ext_irq1_pin,
	input wire logic tmr0_ovf_set,
	input wire logic tmr1_ovf_set,
	input wire logic rx_done_set,
	input wire logic tx_done_set,
	input wire logic tmr2_ovf_set,
	input wire logic tmr2_ext_set,
	// Flag view for the peripherals
	output logic [7:0] flags
);
	import tlvi_pkg::*;

	tlvi_state_t st; // Registered state
	tlvi_state_t next_st; // Next state

	// Pick the first set request in fixed order
	function automatic logic [2:0] pick(input logic [5:0] req);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = 5; i >= 0; i--)
		begin
			if (req[i])
			begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction

	// Source view of the eight flags: serial and timer 2 are OR pairs
	function automatic logic [5:0] src_of(input logic [7:0] f);
		return {f[7] | f[6], f[5] | f[4], f[3:0]};
	endfunction

	// Word address a bus address points at; low two bits never select a register
	function automatic logic [7:0] word_addr(input logic [7:0] a);
		return {a[7:2], 2'h0};
	endfunction

	logic wr_go; // Write address and data taken this cycle
	logic [7:0] wr_addr; // Word address of the write
	logic rd_go; // Read address taken this cycle
	logic block; // Call is blocked this poll
	logic [5:0] req_en; // Enabled requests from last samples
	logic [5:0] req_hi; // Eligible high-level requests
	logic [5:0] req_lo; // Eligible low-level requests
	logic do_call; // Call issued at this poll
	logic [2:0] win; // Winning source index
	logic [7:0] set_ev; // Hardware set events
	logic [31:0] rd_val; // Read mux output
	logic rd_err; // Unmapped read

	// Bus decode and read mux
	always_comb
	begin
		wr_go = st.axi.awready;
		wr_addr = word_addr(axi_req.awaddr);
		rd_go = st.axi.arready;
		rd_err = 1'b0;
		rd_val = 32'h0;
		if (word_addr(axi_req.araddr) == `TLVI_ADDR_ENABLE)
			rd_val = {24'h0, st.ena};
		else if (word_addr(axi_req.araddr) == `TLVI_ADDR_PRIORITY)
			rd_val = {26'h0, st.pri};
		else if (word_addr(axi_req.araddr) == `TLVI_ADDR_CTRL)
			rd_val = {30'h0, st.edge_sel};
		else if (word_addr(axi_req.araddr) == `TLVI_ADDR_FLAGS)
			rd_val = {24'h0, st.flags};
		else if (word_addr(axi_req.araddr) == `TLVI_ADDR_STATUS)
			rd_val = {14'h0, st.inprog, st.call_vector};
		else
			rd_err = 1'b1;
	end

	// Poll: only last machine cycle's samples count, nothing is queued
	always_comb
	begin
		// Return or enable/priority write in this instruction blocks
		block = st.blk | return_from_isr_exec;
		if (wr_go && axi_req.wstrb[0] &&
			(wr_addr == `TLVI_ADDR_ENABLE || wr_addr == `TLVI_ADDR_PRIORITY))
			block = 1'b1;
		req_en = st.samp & st.ena[5:0] & {6{st.ena[`TLVI_EN_GLOBAL]}};
		// High level runs only if no high routine is active
		req_hi = st.inprog[1] ? 6'h0 : (req_en & st.pri);
		// Low level needs both levels idle
		req_lo = (st.inprog != 2'h0) ? 6'h0 : (req_en & ~st.pri);
		// Higher level first, order inside the level
		win = (req_hi != 6'h0) ? pick(req_hi) : pick(req_lo);
		do_call = mc_end && last_cycle && !block && (req_hi | req_lo) != 6'h0;
	end

	// Next state
	always_comb
	begin
		next_st = st;
		set_ev = {tmr2_ext_set, tmr2_ovf_set, tx_done_set, rx_done_set,
			tmr1_ovf_set, 1'b0, tmr0_ovf_set, 1'b0};
		// Write channel: take address and data together
		next_st.axi.awready = axi_req.awvalid && axi_req.wvalid && !st.axi.awready && !st.axi.bvalid;
		next_st.axi.wready = next_st.axi.awready;
		if (wr_go)
		begin
			next_st.axi.bvalid = 1'b1;
			next_st.axi.bresp = `TLVI_RESP_OKAY;
			if (wr_addr == `TLVI_ADDR_ENABLE)
			begin
				if (axi_req.wstrb[0])
					next_st.ena = axi_req.wdata[7:0];
			end
			else if (wr_addr == `TLVI_ADDR_PRIORITY)
			begin
				if (axi_req.wstrb[0])
					next_st.pri = axi_req.wdata[5:0];
			end
			else if (wr_addr == `TLVI_ADDR_CTRL)
			begin
				if (axi_req.wstrb[0])
					next_st.edge_sel = axi_req.wdata[1:0];
			end
			else if (wr_addr == `TLVI_ADDR_FLAGS)
			begin
				// Software sets or clears any flag like hardware would
				if (axi_req.wstrb[0])
					next_st.flags = axi_req.wdata[7:0];
			end
			else if (wr_addr != `TLVI_ADDR_STATUS)
				next_st.axi.bresp = `TLVI_RESP_SLVERR;
		end
		else if (st.axi.bvalid && axi_req.bready)
			next_st.axi.bvalid = 1'b0;
		// Read channel: one read at a time
		next_st.axi.arready = axi_req.arvalid && !st.axi.arready && !st.axi.rvalid;
		if (rd_go)
		begin
			next_st.axi.rvalid = 1'b1;
			next_st.axi.rdata = rd_val;
			next_st.axi.rresp = rd_err ? `TLVI_RESP_SLVERR : `TLVI_RESP_OKAY;
		end
		else if (st.axi.rvalid && axi_req.rready)
			next_st.axi.rvalid = 1'b0;
		// Blocking window closes at the end of the current instruction
		if (mc_end && last_cycle)
			next_st.blk = 1'b0;
		else if (block)
			next_st.blk = 1'b1;
		next_st.call_valid = 1'b0;
		if (do_call)
		begin
			// Counter push is the sequencer's; status word is not saved
			next_st.call_valid = 1'b1;
			next_st.call_vector = `TLVI_VEC_BASE + (`TLVI_VEC_STEP * {13'h0, win});
			if (req_hi != 6'h0)
				next_st.inprog[1] = 1'b1;
			else
				next_st.inprog[0] = 1'b1;
			// Timer 0/1 cleared, serial and timer 2 left for software
			if (win == 3'h1)
				next_st.flags[`TLVI_F_TMR0] = 1'b0;
			if (win == 3'h3)
				next_st.flags[`TLVI_F_TMR1] = 1'b0;
			// External flag cleared only when edge triggered
			if (win == 3'h0 && st.edge_sel[0])
				next_st.flags[`TLVI_F_EXT0] = 1'b0;
			if (win == 3'h2 && st.edge_sel[1])
				next_st.flags[`TLVI_F_EXT1] = 1'b0;
		end
		else if (mc_end && return_from_isr_exec)
		begin
			// Return drops the highest active level; plain return never reaches here
			if (st.inprog[1])
				next_st.inprog[1] = 1'b0;
			else
				next_st.inprog[0] = 1'b0;
		end
		// Hardware set wins over any clear in the same cycle
		next_st.flags = next_st.flags | set_ev;
		if (mc_end)
		begin
			// Pins: low level in level mode, high then low in edge mode
			next_st.pin_prev = {ext_irq1_pin, ext_irq0_pin};
			if (!st.edge_sel[0])
				next_st.flags[`TLVI_F_EXT0] = !ext_irq0_pin;
			else if (st.pin_prev[0] && !ext_irq0_pin)
				next_st.flags[`TLVI_F_EXT0] = 1'b1;
			if (!st.edge_sel[1])
				next_st.flags[`TLVI_F_EXT1] = !ext_irq1_pin;
			else if (st.pin_prev[1] && !ext_irq1_pin)
				next_st.flags[`TLVI_F_EXT1] = 1'b1;
			// Samples taken now are polled at the next machine cycle
			next_st.samp = src_of(st.flags);
		end
	end

	// State register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st <= '0;
			st.pin_prev <= 2'h3;
		end
		else
			st <= next_st;
	end

	// Outputs straight from the state flops
	assign axi_rsp = st.axi;
	assign call_valid = st.call_valid;
	assign call_vector = st.call_vector;
	assign inprog = st.inprog;
	assign flags = st.flags;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Priority starts at all-low after reset
	property p_pri_reset;
		$rose(aresetn) |-> st.pri == 6'h0;
	endproperty
	a_pri_reset: assert property (p_pri_reset) else $error("priority not cleared by reset");

	// A call only closes an instruction's last cycle
	property p_call_last;
		call_valid |-> $past(mc_end) && $past(last_cycle);
	endproperty
	a_call_last: assert property (p_call_last) else $error("call not at instruction end");

	// No call right after a return or a blocking access
	property p_call_unblocked;
		call_valid |-> !$past(st.blk) && !$past(return_from_isr_exec);
	endproperty
	a_call_unblocked: assert property (p_call_unblocked) else $error("call while blocked");

	// A running high routine is never preempted
	property p_hi_no_preempt;
		call_valid |-> !$past(st.inprog[1]);
	endproperty
	a_hi_no_preempt: assert property (p_hi_no_preempt) else $error("high routine preempted");

	// Vector lies on the fixed table
	property p_vec_table;
		call_valid |-> call_vector inside {16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b};
	endproperty
	a_vec_table: assert property (p_vec_table) else $error("vector off table");

	// Timer 0 flag is gone after its own call
	property p_tmr0_clear;
		call_valid && call_vector == 16'h000b |-> !st.flags[`TLVI_F_TMR0] || $past(tmr0_ovf_set);
	endproperty
	a_tmr0_clear: assert property (p_tmr0_clear) else $error("timer 0 flag not cleared");

	// Serial flag survives the call
	property p_serial_kept;
		call_valid && $past(st.flags[`TLVI_F_RX]) && !$past(wr_go) |-> st.flags[`TLVI_F_RX];
	endproperty
	a_serial_kept: assert property (p_serial_kept) else $error("serial flag cleared by call");

	// A call always leaves a level in progress
	property p_inprog_set;
		call_valid |-> inprog != 2'h0 ##1 inprog != 2'h0 || $past(return_from_isr_exec);
	endproperty
	a_inprog_set: assert property (p_inprog_set) else $error("no level marked in progress");

	// Return drops the high level first
	property p_return_from_isr_hi;
		mc_end && return_from_isr_exec && st.inprog == 2'h3 |=> inprog == 2'h1;
	endproperty
	a_return_from_isr_hi: assert property (p_return_from_isr_hi) else $error("return cleared wrong level");

	// A running low routine yields only to a high call
	property p_lo_yields_hi;
		call_valid && $past(st.inprog[0]) |-> inprog[1];
	endproperty
	a_lo_yields_hi: assert property (p_lo_yields_hi) else $error("low routine preempted by low");

	// An enabled high sample always wins the poll
	property p_hi_wins;
		call_valid && $past(st.ena[`TLVI_EN_GLOBAL]) && $past((st.samp & st.ena[5:0] & st.pri) != 6'h0)
			|-> inprog[1];
	endproperty
	a_hi_wins: assert property (p_hi_wins) else $error("low call despite high request");

	// A fresh low call takes external 0 whenever it was sampled
	property p_order_ext0;
		call_valid && !$past(st.inprog[0]) && inprog[0] && $past(st.samp[0] && st.ena[0] && !st.pri[0])
			|-> call_vector == 16'h0003;
	endproperty
	a_order_ext0: assert property (p_order_ext0) else $error("external 0 passed over");

	// Samples move only at the machine cycle point
	property p_sample_hold;
		!mc_end |=> $stable(st.samp);
	endproperty
	a_sample_hold: assert property (p_sample_hold) else $error("samples moved between machine cycles");

	// An enable or priority write holds off the call of that cycle
	property p_access_blocks;
		wr_go && axi_req.wstrb[0] && (wr_addr == `TLVI_ADDR_ENABLE || wr_addr == `TLVI_ADDR_PRIORITY)
			|=> !call_valid;
	endproperty
	a_access_blocks: assert property (p_access_blocks) else $error("call beside a blocking access");

	// A call needs a set sample from the last machine cycle
	property p_fresh_sample;
		call_valid |-> $past(st.samp != 6'h0);
	endproperty
	a_fresh_sample: assert property (p_fresh_sample) else $error("call without a polled sample");

	// Timer 2 overflow flag survives its own call
	property p_t2_kept;
		call_valid && call_vector == 16'h002b && $past(st.flags[`TLVI_F_T2OV]) && !$past(wr_go)
			|-> st.flags[`TLVI_F_T2OV];
	endproperty
	a_t2_kept: assert property (p_t2_kept) else $error("timer 2 flag cleared by call");

	// Edge mode: external 0 flag is gone after its call unless a new edge came
	property p_ext_edge_clear;
		call_valid && call_vector == 16'h0003 && $past(st.edge_sel[0])
			|-> !st.flags[`TLVI_F_EXT0] || ($past(st.pin_prev[0]) && !$past(ext_irq0_pin));
	endproperty
	a_ext_edge_clear: assert property (p_ext_edge_clear) else $error("edge flag kept after call");

	// Edge mode: a high then low sample raises the external 0 flag
	property p_edge_set;
		mc_end && st.edge_sel[0] && st.pin_prev[0] && !ext_irq0_pin |=> flags[`TLVI_F_EXT0];
	endproperty
	a_edge_set: assert property (p_edge_set) else $error("falling edge not flagged");

	// Only a return drops an in-progress level
	property p_inprog_hold;
		inprog != 2'h0 && !(mc_end && return_from_isr_exec) |=> inprog != 2'h0;
	endproperty
	a_inprog_hold: assert property (p_inprog_hold) else $error("level dropped without return");
endmodule

// >>> src/tlvi_defs.svh
// Purpose: constants for the two-level vectored interrupt unit
// Assumes: AXI4-Lite byte addresses, 32-bit data
// Notes: types live in tlvi_pkg
`ifndef TLVI_DEFS_SVH
`define TLVI_DEFS_SVH
`define TLVI_ADDR_ENABLE 8'ha8
`define TLVI_ADDR_PRIORITY 8'hb8
`define TLVI_ADDR_CTRL 8'hc0
`define TLVI_ADDR_FLAGS 8'hc4
`define TLVI_ADDR_STATUS 8'hc8
`define TLVI_RESP_OKAY 2'h0
`define TLVI_RESP_SLVERR 2'h2
`define TLVI_EN_GLOBAL 7
`define TLVI_VEC_BASE 16'h0003
`define TLVI_VEC_STEP 16'h0008
`define TLVI_F_EXT0 0
`define TLVI_F_TMR0 1
`define TLVI_F_EXT1 2
`define TLVI_F_TMR1 3
`define TLVI_F_RX 4
`define TLVI_F_TX 5
`define TLVI_F_T2OV 6
`define TLVI_F_T2EX 7
`endif

// >>> src/tlvi_pkg.sv
// Purpose: types for the two-level vectored interrupt unit
// Assumes: used with tlvi_defs.svh
// Notes: state is one packed struct
package tlvi_pkg;
	// AXI4-Lite master to slave
	typedef struct packed {
		logic [7:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [7:0] araddr;
		logic arvalid;
		logic rready;
	} tlvi_axi_req_t;
	// AXI4-Lite slave to master
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} tlvi_axi_rsp_t;
	// Whole state of the unit
	typedef struct packed {
		tlvi_axi_rsp_t axi;
		logic [5:0] pri;
		logic [7:0] ena;
		logic [1:0] edge_sel;
		logic [7:0] flags;
		logic [5:0] samp;
		logic [1:0] pin_prev;
		logic [1:0] inprog;
		logic blk;
		logic call_valid;
		logic [15:0] call_vector;
	} tlvi_state_t;
endpackage

// >>> tb/tlvi_seq_model.sv
// Purpose: instruction sequencer stand-in for the interrupt unit
// Assumes: the bench sets the instruction kind right after an mc_end edge
// Notes: a machine cycle is shortened to MC_LEN clocks to keep runs short
`timescale 1ns/1ns
module tlvi_seq_model #(parameter int MC_LEN = 4) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Instruction kind chosen by the bench
	input wire logic lc_cmd,
	input wire logic rt_cmd,
	// Sequencer outputs
	output logic mc_end,
	output logic last_cycle,
	output logic return_from_isr_exec
);
	logic [7:0] cnt; // Clock count within a machine cycle
	// Levels stand for the whole machine cycle, as the bench holds them
	assign last_cycle = lc_cmd;
	assign return_from_isr_exec = rt_cmd;
	// One mc_end pulse per machine cycle, none in reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt <= 8'h00;
			mc_end <= 1'b0;
		end
		else
		begin
			cnt <= (cnt == 8'(MC_LEN - 1)) ? 8'h00 : cnt + 8'h01;
			mc_end <= (cnt == 8'(MC_LEN - 2));
		end
	end
endmodule

// >>> tb/tb_top.sv
// Purpose: self-checking bench for the interrupt unit
// Assumes: one clock, registers over AXI4-Lite
// Notes: drivers queue expected results; a watcher compares them
`timescale 1ns/1ns
`include "tlvi_defs.svh"
module tb_top;
	import tlvi_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0; // Active low, synchronous
	tlvi_axi_req_t req = '0;
	tlvi_axi_rsp_t rsp;
	logic lc = 1'b0; // Current cycle ends the instruction
	logic rt = 1'b0; // Current instruction is a return
	logic mc_end;
	logic last_cycle;
	logic return_from_isr_exec;
	logic call_valid;
	logic [15:0] call_vector;
	logic [1:0] inprog;
	logic [1:0] pin = 2'h3; // External pins idle high
	logic [5:0] setv = 6'h00; // Set pulses tmr0,tmr1,rx,tx,t2ov,t2ex
	logic [7:0] flags;
	logic [15:0] vq[$]; // Expected call vectors
	logic [33:0] rq[$]; // Expected read {resp, data}
	logic [1:0] bq[$]; // Expected write responses
	int err_total = 0;
	int n_compared = 0;
	initial
	begin
		forever #2 aclk = ~aclk;
	end
	tlvi_top tlvi_top_i(.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .mc_end(mc_end),
		.last_cycle(last_cycle), .return_from_isr_exec(return_from_isr_exec), .call_valid(call_valid), .call_vector(call_vector),
		.inprog(inprog), .ext_irq0_pin(pin[0]), .ext_irq1_pin(pin[1]), .tmr0_ovf_set(setv[0]),
		.tmr1_ovf_set(setv[1]), .rx_done_set(setv[2]), .tx_done_set(setv[3]), .tmr2_ovf_set(setv[4]),
		.tmr2_ext_set(setv[5]), .flags(flags));
	tlvi_seq_model tlvi_seq_model_i(.aclk(aclk), .aresetn(aresetn), .lc_cmd(lc), .rt_cmd(rt),
		.mc_end(mc_end), .last_cycle(last_cycle), .return_from_isr_exec(return_from_isr_exec));
	task automatic miss(input string m);
		$display("MISMATCH t=%0t %s", $time, m);
		err_total++;
	endtask
	task automatic cmp(input logic [33:0] got, input logic [33:0] exp, input string m);
		n_compared++;
		if (got !== exp)
			miss(m);
	endtask
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Watcher: every result that appears takes the oldest note
	always @(posedge aclk)
	begin
		if (call_valid === 1'b1)
			if (vq.size() == 0)
				miss("unexpected call");
			else
				cmp(34'(call_vector), 34'(vq.pop_front()), "call vector");
		if (rsp.rvalid === 1'b1 && req.rready === 1'b1)
			cmp({rsp.rresp, rsp.rdata}, rq.pop_front(), "read data");
		if (rsp.bvalid === 1'b1 && req.bready === 1'b1)
			cmp(34'(rsp.bresp), 34'(bq.pop_front()), "write response");
	end
	// One AXI4-Lite transfer; valids drop when taken, ready waits for the answer
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] exp);
		int k;
		@(posedge aclk);
		if (w)
		begin
			req <= '{awaddr:a, awvalid:1'b1, wdata:d, wstrb:4'hf, wvalid:1'b1, bready:1'b1, default:'0};
			bq.push_back(exp[33:32]);
		end
		else
		begin
			req <= '{araddr:a, arvalid:1'b1, rready:1'b1, default:'0};
			rq.push_back(exp);
		end
		for (k = 0; k < 20; k++)
		begin
			@(posedge aclk);
			// Each channel lets go of its valid only when its own ready is seen
			if (rsp.awready === 1'b1)
				req.awvalid <= 1'b0;
			if (rsp.wready === 1'b1)
				req.wvalid <= 1'b0;
			if (rsp.arready === 1'b1)
				req.arvalid <= 1'b0;
			if (rsp.bvalid === 1'b1 || rsp.rvalid === 1'b1)
				break;
		end
		req.bready <= 1'b0;
		req.rready <= 1'b0;
		if (k == 20)
		begin
			miss("bus stalled");
			conclude();
		end
	endtask
	// One machine cycle of the given kind, ending at its mc_end edge
	task automatic mcyc(input logic l, input logic r);
		int k;
		@(posedge aclk);
		lc <= l;
		rt <= r;
		for (k = 0; k < 20; k++)
		begin
			@(posedge aclk);
			if (mc_end === 1'b1)
				break;
		end
		// The kind covers this cycle only; cycles spent on the bus after it are plain middle cycles
		lc <= 1'b0;
		rt <= 1'b0;
		if (k == 20)
		begin
			miss("no machine cycle");
			conclude();
		end
	endtask
	task automatic pulse(input logic [5:0] v);
		@(posedge aclk);
		setv <= v;
		@(posedge aclk);
		setv <= 6'h00;
	endtask
	// In-progress levels, looked at once settled
	task automatic ip(input logic [1:0] e);
		@(negedge aclk);
		cmp(34'(inprog), 34'(e), "in progress");
	endtask
	initial
	begin
		logic [31:0] rv;
		int i;
		logic [15:0] vecs[6] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b};
		rv = $urandom(96266);
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		bus(0, `TLVI_ADDR_PRIORITY, 0, 34'h0);
		bus(0, `TLVI_ADDR_ENABLE, 0, 34'h0);
		bus(0, 8'h10, 0, {`TLVI_RESP_SLVERR, 32'h0});
		rv = $urandom();
		bus(1, `TLVI_ADDR_PRIORITY, rv, 34'h0);
		bus(0, `TLVI_ADDR_PRIORITY, 0, {28'h0, rv[5:0]});
		$display("test registers done");
		// All six sources pending at one level, taken one by one
		bus(1, `TLVI_ADDR_PRIORITY, 0, 0);
		bus(1, `TLVI_ADDR_CTRL, 32'h3, 0);
		bus(1, `TLVI_ADDR_ENABLE, 32'hbf, 0);
		mcyc(1, 0);
		pin <= 2'h0;
		pulse(6'h3f);
		mcyc(0, 0);
		mcyc(0, 0);
		for (i = 0; i < 6; i++)
		begin
			vq.push_back(vecs[i]);
			mcyc(1, 0);
			mcyc(0, 0);
			ip(2'h1);
			if (i == 4)
			begin
				bus(0, `TLVI_ADDR_FLAGS, 0, 34'hf0);
				@(negedge aclk);
				cmp(34'(flags), 34'hf0, "flag view");
			end
			if (i >= 4)
				bus(1, `TLVI_ADDR_FLAGS, (i == 4) ? 32'hc0 : 32'h0, 0);
			mcyc(1, 1);
			ip(2'h0);
		end
		$display("test order done");
		// Timer 1 made high; preemption and returns
		bus(1, `TLVI_ADDR_PRIORITY, 32'h8, 0);
		mcyc(1, 0);
		pulse(6'h03);
		mcyc(1, 0);
		vq.push_back(16'h001b);
		mcyc(1, 0);
		mcyc(1, 0);
		ip(2'h2);
		mcyc(1, 1);
		vq.push_back(16'h000b);
		mcyc(1, 0);
		pulse(6'h02);
		mcyc(0, 0);
		vq.push_back(16'h001b);
		mcyc(1, 0);
		mcyc(0, 0);
		ip(2'h3);
		mcyc(1, 1);
		ip(2'h1);
		mcyc(1, 0);
		ip(2'h1);
		pulse(6'h04);
		mcyc(0, 0);
		mcyc(1, 0);
		bus(1, `TLVI_ADDR_FLAGS, 0, 0);
		mcyc(1, 1);
		mcyc(1, 0);
		mcyc(1, 0);
		ip(2'h0);
		$display("test preemption done");
		// Level mode, with an enable write holding off the call
		mcyc(0, 0);
		bus(1, `TLVI_ADDR_PRIORITY, 0, 0);
		bus(1, `TLVI_ADDR_CTRL, 0, 0);
		mcyc(0, 0);
		mcyc(0, 0);
		bus(1, `TLVI_ADDR_ENABLE, 32'h81, 0);
		mcyc(1, 0);
		vq.push_back(16'h0003);
		mcyc(1, 0);
		mcyc(0, 0);
		bus(0, `TLVI_ADDR_FLAGS, 0, 34'h5);
		pin <= 2'h3;
		mcyc(0, 0);
		mcyc(1, 1);
		mcyc(1, 0);
		mcyc(1, 0);
		ip(2'h0);
		cmp(34'(vq.size()), 34'h0, "calls missing");
		$display("test level done");
		conclude();
	end
endmodule
